// *** hw/dps_pkg.sv ***
`default_nettype none
// ==========================================
// Shared constants for the debug pin resynchronisation link.
package dps_pkg;
	// Serial clock period of the debug link, in core clock cycles.
	localparam int SER_DIV_DEFAULT = 4;
	// Least host request length, in serial cycles.
	localparam int REQ_LOW_CYCLES = 128;
	// Target guard delay after the line rises, in serial cycles.
	localparam int GUARD_CYCLES = 16;
	// Target response low length, in serial cycles.
	localparam int RESP_LOW_CYCLES = 128;
	// Speedup pulse length, in serial cycles.
	localparam int SPEEDUP_CYCLES = 1;
	// Width of the serial and core cycle counters.
	localparam int CNT_W = 16;

	// Target states.
	typedef enum logic [2:0] {
		T_IDLE  = 3'b000,
		T_LOW   = 3'b001,
		T_WAITH = 3'b010,
		T_GUARD = 3'b011,
		T_RESP  = 3'b100,
		T_SPEED = 3'b101
	} dps_tstate_e;

	// Host states.
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_REQ   = 3'b001,
		H_SPEED = 3'b010,
		H_WAITL = 3'b011,
		H_MEAS  = 3'b100
	} dps_hstate_e;
endpackage
`default_nettype wire

// *** hw/dps_link_if.sv ***
`default_nettype none
// ==========================================
// Single debug wire between host pod and target, open with pull-up.
interface dps_link_if;
	logic hostOut;   // Host drive level.
	logic hostOe_n;  // Host drives when low.
	logic tgtOut;    // Target drive level.
	logic tgtOe_n;   // Target drives when low.
	logic pinLevel;  // Resolved wire level, computed by the bench.

	modport host (output hostOut, output hostOe_n, input pinLevel);
	modport target (output tgtOut, output tgtOe_n, input pinLevel);
endinterface
`default_nettype wire

// *** hw/dps_target.sv ***
`default_nettype none
// ==========================================
// Target end: detects a long low, answers with a timed pulse.
module dps_target #(
	parameter int SER_DIV = dps_pkg::SER_DIV_DEFAULT  // Core cycles per serial cycle.
) (
	input  wire logic     core_clk,     // Core clock.
	input  wire logic     rst_n,        // Asynchronous reset, active low.
	dps_link_if.target    link,         // Debug wire.
	input  wire logic     ackPending,   // Acknowledge pulse pending in the command logic.
	output var  logic     softReset,    // One-cycle pulse: drop partial command or ack.
	output var  logic     syncBusy,     // High while a request is handled.
	output var  logic     cmdStart      // One-cycle pulse: falling edge starting a command.
);
	localparam int CW = dps_pkg::CNT_W;

	// Sequencer state.
	dps_pkg::dps_tstate_e state;          // Present step of the exchange.
	dps_pkg::dps_tstate_e next_state;     // Step after this edge.
	logic [CW-1:0]        serCnt;         // Serial cycles counted in the present step.
	logic [CW-1:0]        next_serCnt;    // Next serial cycle count.
	logic                 lastPin;        // Pin level at the previous edge.
	logic                 next_lastPin;   // Pin level kept for the next edge.
	logic                 next_softReset; // Next soft reset pulse.
	logic                 next_syncBusy;  // Next busy level.
	logic                 next_cmdStart;  // Next command start pulse.
	logic                 reqHit;         // Request length reached at this edge.
	// Prescaler state.
	logic [CW-1:0]        preCnt;         // Core cycles into the present serial cycle.
	logic [CW-1:0]        next_preCnt;    // Next prescaler count.
	logic                 preLoad;        // Restart the prescaler at this edge.
	logic [CW-1:0]        preLoadVal;     // Count the prescaler restarts from.
	logic                 tick;           // Last core cycle of a serial cycle.
	logic                 fallSeen;       // Falling edge of the pin at this edge.
	// Pin driver state.
	logic                 tOut;           // Registered drive level.
	logic                 next_tOut;      // Next drive level.
	logic                 tOe_n;          // Registered drive enable, low to drive.
	logic                 next_tOe_n;     // Next drive enable.

	// The pin is driven only from registers, so no glitch reaches the wire.
	assign link.tgtOut  = tOut;
	assign link.tgtOe_n = tOe_n;
	assign tick         = (preCnt == CW'(SER_DIV - 1));
	assign fallSeen     = lastPin && !link.pinLevel;

	// ==========================================
	// Prescaler: one serial cycle is SER_DIV core cycles.
	// The count restarts at the start of each timed step, so every step is
	// measured from the edge that began it rather than from a free-running phase.
	// SER_DIV must be at least 2, since the request count starts one cycle in.
	always_comb begin
		if (preLoad) begin
			next_preCnt = preLoadVal;
		end else if (tick) begin
			next_preCnt = '0;
		end else begin
			next_preCnt = preCnt + 1'b1;
		end
	end

	// Prescaler register.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			preCnt <= '0;
		end else begin
			preCnt <= next_preCnt;
		end
	end

	// ==========================================
	// Sequencer: request detection, guard delay and timed reply.
	// Every timed step counts whole serial cycles at the present rate.
	always_comb begin
		next_state    = state;
		next_serCnt   = serCnt;
		next_lastPin  = link.pinLevel;
		next_cmdStart = 1'b0;
		reqHit        = 1'b0;
		preLoad       = 1'b0;
		preLoadVal    = '0;
		unique case (state)
			dps_pkg::T_IDLE: begin
				if (fallSeen) begin
					next_state    = dps_pkg::T_LOW;
					next_serCnt   = '0;
					next_cmdStart = 1'b1;
					// The edge sample is already the first low core cycle, so a low
					// of exactly the request length is still recognised.
					preLoad       = 1'b1;
					preLoadVal    = CW'(1);
				end
			end
			dps_pkg::T_LOW: begin
				// Short lows belong to command bits; only a long low is a request.
				if (link.pinLevel) begin
					next_state = dps_pkg::T_IDLE;
				end else if (tick) begin
					next_serCnt = serCnt + 1'b1;
					if (serCnt == CW'(dps_pkg::REQ_LOW_CYCLES - 1)) begin
						next_state = dps_pkg::T_WAITH;
						reqHit     = 1'b1;
					end
				end
			end
			dps_pkg::T_WAITH: begin
				// wait for high
				// A host may stretch its request; the guard only starts once the line is up.
				if (link.pinLevel) begin
					next_state  = dps_pkg::T_GUARD;
					next_serCnt = '0;
					preLoad     = 1'b1;
				end
			end
			dps_pkg::T_GUARD: begin
				if (tick) begin
					next_serCnt = serCnt + 1'b1;
					if (serCnt == CW'(dps_pkg::GUARD_CYCLES - 1)) begin
						next_state  = dps_pkg::T_RESP;
						next_serCnt = '0;
					end
				end
			end
			dps_pkg::T_RESP: begin
				if (tick) begin
					next_serCnt = serCnt + 1'b1;
					if (serCnt == CW'(dps_pkg::RESP_LOW_CYCLES - 1)) begin
						next_state  = dps_pkg::T_SPEED;
						next_serCnt = '0;
					end
				end
			end
			dps_pkg::T_SPEED: begin
				if (tick) begin
					next_serCnt = serCnt + 1'b1;
					if (serCnt == CW'(dps_pkg::SPEEDUP_CYCLES - 1)) begin
						next_state   = dps_pkg::T_IDLE;
						next_serCnt  = '0;
						// The pin is still high from the speedup, so no edge is owed.
						next_lastPin = 1'b1;
					end
				end
			end
			default: begin
				next_state = dps_pkg::T_IDLE;
			end
		endcase
		// cancels pending ack
		// A pending acknowledge is dropped by the same pulse as a partial command.
		next_softReset = reqHit | (reqHit & ackPending);
		next_syncBusy  = (next_state != dps_pkg::T_IDLE) && (next_state != dps_pkg::T_LOW);
	end

	// Sequencer registers. Pulses and the busy flag come straight from here.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= dps_pkg::T_IDLE;
			serCnt    <= '0;
			lastPin   <= 1'b1;
			softReset <= 1'b0;
			syncBusy  <= 1'b0;
			cmdStart  <= 1'b0;
		end else begin
			state     <= next_state;
			serCnt    <= next_serCnt;
			lastPin   <= next_lastPin;
			softReset <= next_softReset;
			syncBusy  <= next_syncBusy;
			cmdStart  <= next_cmdStart;
		end
	end

	// ==========================================
	// Pin driver: low through the reply, high for the speedup, released otherwise.
	// Deriving it from the next step keeps drive and step changes on the same edge.
	// drive low
	always_comb begin
		next_tOe_n = !((next_state == dps_pkg::T_RESP) || (next_state == dps_pkg::T_SPEED));
		next_tOut  = (next_state != dps_pkg::T_RESP);
	end

	// Pin driver registers. Reset leaves the pin released at its idle level.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tOut  <= 1'b1;
			tOe_n <= 1'b1;
		end else begin
			tOut  <= next_tOut;
			tOe_n <= next_tOe_n;
		end
	end
endmodule
`default_nettype wire

// *** hw/dps_host.sv ***
`default_nettype none
// ==========================================
// Host pod end: sends a long low, then measures the target's reply.
module dps_host #(
	parameter int REQ_CORE_CYCLES = dps_pkg::REQ_LOW_CYCLES * 16  // Request low length in core cycles.
) (
	input  wire logic                     core_clk,   // Core clock.
	input  wire logic                     rst_n,      // Asynchronous reset, active low.
	dps_link_if.host                      link,       // Debug wire.
	input  wire logic                     syncReq,    // Pulse: start a resynchronisation.
	output var  logic                     busy,       // High while a request runs.
	output var  logic                     done,       // One-cycle pulse: measurement ready.
	output var  logic [dps_pkg::CNT_W-1:0] lowTime    // Measured response low, core cycles.
);
	localparam int CW = dps_pkg::CNT_W;

	dps_pkg::dps_hstate_e state, next_state;
	logic [CW-1:0] cnt, next_cnt, next_lowTime;
	logic          next_busy, next_done;
	logic          hOut, next_hOut, hOe_n, next_hOe_n;

	assign link.hostOut = hOut;
	assign link.hostOe_n = hOe_n;

	// ==========================================
	// Next state.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_lowTime = lowTime;
		next_done = 1'b0;
		next_hOut = hOut;
		next_hOe_n = hOe_n;
		unique case (state)
			dps_pkg::H_IDLE: begin
				if (syncReq) begin
					next_state = dps_pkg::H_REQ;
					next_cnt = '0;
					next_hOut = 1'b0;
					next_hOe_n = 1'b0;
				end
			end
			dps_pkg::H_REQ: begin
				next_cnt = cnt + 1'b1;
				if (cnt == CW'(REQ_CORE_CYCLES - 1)) begin
					next_state = dps_pkg::H_SPEED;
					next_hOut = 1'b1;
				end
			end
			dps_pkg::H_SPEED: begin
				next_state = dps_pkg::H_WAITL;
				next_hOe_n = 1'b1;
			end
			dps_pkg::H_WAITL: begin
				if (!link.pinLevel) begin
					next_state = dps_pkg::H_MEAS;
					next_cnt = CW'(1);
				end
			end
			dps_pkg::H_MEAS: begin
				if (link.pinLevel) begin
					next_state = dps_pkg::H_IDLE;
					next_lowTime = cnt;
					next_done = 1'b1;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			default: begin
				next_state = dps_pkg::H_IDLE;
				next_hOe_n = 1'b1;
			end
		endcase
		next_busy = (next_state != dps_pkg::H_IDLE);
	end

	// ==========================================
	// Registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= dps_pkg::H_IDLE;
			cnt <= '0;
			lowTime <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			hOut <= 1'b1;
			hOe_n <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			lowTime <= next_lowTime;
			busy <= next_busy;
			done <= next_done;
			hOut <= next_hOut;
			hOe_n <= next_hOe_n;
		end
	end
endmodule
`default_nettype wire

// *** verification/dps_link_chk.sv ***
`default_nettype none
// ==========================================
// Wire checks for the resynchronisation link.
module dps_link_chk #(
	parameter int REQ  = 512, // Host request low, core cycles.
	parameter int RESP = 512  // Target reply low, core cycles.
) (
	input wire logic core_clk, // Core clock.
	input wire logic rst_n,    // Reset, active low.
	input wire logic hostOut,  // Host level.
	input wire logic hostOe_n, // Host drives when low.
	input wire logic tgtOut,   // Target level.
	input wire logic tgtOe_n,  // Target drives when low.
	input wire logic pinLevel  // Wire level.
);
	logic [15:0] hLow;
	logic [15:0] tLow;
	logic [15:0] hiCnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Run lengths in counters, since the pulses are far too long to unroll.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hLow <= 16'h0000;
			tLow <= 16'h0000;
			hiCnt <= 16'h0000;
		end else begin
			hLow <= (!hostOe_n && !hostOut) ? hLow + 16'h0001 : 16'h0000;
			tLow <= (!tgtOe_n && !tgtOut) ? tLow + 16'h0001 : 16'h0000;
			hiCnt <= pinLevel ? hiCnt + 16'h0001 : 16'h0000;
		end
	end
	AST_HOST_REQ_LEN: assert property ($rose(hostOut) && !hostOe_n |-> hLow == REQ)
		else $error("host request low has wrong length");
	AST_HOST_SPEEDUP: assert property ($rose(hostOut) && !hostOe_n |=> hostOe_n)
		else $error("host speedup not one cycle then release");
	AST_HOST_OFF: assert property (!tgtOe_n |-> hostOe_n)
		else $error("host drives during target reply");
	AST_TGT_ANSWERS: assert property ($rose(hostOe_n) |-> ##[60:80] !tgtOe_n)
		else $error("target reply missing after release");
	AST_TGT_GUARD: assert property ($fell(tgtOe_n) |-> hiCnt >= 64 && hiCnt <= 67)
		else $error("target guard delay wrong");
	AST_TGT_FIRST_LOW: assert property ($fell(tgtOe_n) |-> !tgtOut)
		else $error("target reply does not start low");
	AST_TGT_LOW_LEN: assert property ($rose(tgtOut) && !tgtOe_n |-> tLow == RESP)
		else $error("target reply low has wrong length");
	AST_TGT_SPEEDUP: assert property ($rose(tgtOut) && !tgtOe_n |-> (tgtOut && !tgtOe_n) [*4] ##1 tgtOe_n)
		else $error("target speedup not four cycles then release");
	C_REQ: cover property ($rose(hostOe_n));
	C_REPLY: cover property ($fell(tgtOe_n));
	C_END: cover property ($rose(tgtOe_n));
endmodule
`default_nettype wire

// *** verification/debug_pin_speed_sync_tb_top.sv ***
`default_nettype none
// ==========================================
// Bench: host and target joined on one wire.
module debug_pin_speed_sync_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 4;
	localparam int RESP = dps_pkg::RESP_LOW_CYCLES * DIV;
	logic core_clk, rst_n, syncReq, ackPending, benchLow, softReset, syncBusy, cmdStart, busy, done;
	logic [dps_pkg::CNT_W-1:0] lowTime;
	int err_total, checks_done, srCnt, csCnt;
	dps_link_if link();
	// Pull-up wire: low if any party drives low.
	assign link.pinLevel = !((!link.hostOe_n && !link.hostOut) || (!link.tgtOe_n && !link.tgtOut) || benchLow);
	dps_target #(.SER_DIV(DIV)) dps_target_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link.target),
		.ackPending(ackPending), .softReset(softReset), .syncBusy(syncBusy), .cmdStart(cmdStart));
	dps_host #(.REQ_CORE_CYCLES(RESP)) dps_host_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link.host),
		.syncReq(syncReq), .busy(busy), .done(done), .lowTime(lowTime));
	dps_link_chk #(.REQ(RESP), .RESP(RESP)) dps_link_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
		.hostOut(link.hostOut), .hostOe_n(link.hostOe_n), .tgtOut(link.tgtOut), .tgtOe_n(link.tgtOe_n),
		.pinLevel(link.pinLevel));
	// Clock and pulse counters.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (softReset === 1'b1) srCnt++;
		if (cmdStart === 1'b1) csCnt++;
	end
	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	// A low far shorter than a request is ordinary command traffic.
	task automatic t_short;
		int s, c;
		s = srCnt;
		c = csCnt;
		benchLow = 1'b1;
		repeat (100) @(posedge core_clk);
		#2 benchLow = 1'b0;
		repeat (200) @(posedge core_clk);
		#2 chk(csCnt == c + 1 && srCnt == s && link.tgtOe_n === 1'b1, "short low handled as sync");
	endtask
	// Full request; a second request while busy must be ignored.
	task automatic t_sync(input logic ack);
		int s, n;
		s = srCnt;
		n = 0;
		ackPending = ack;
		syncReq = 1'b1;
		@(posedge core_clk);
		#2 syncReq = 1'b0;
		repeat (200) @(posedge core_clk);
		#2 chk(busy === 1'b1 && link.pinLevel === 1'b0, "host not holding its request low");
		syncReq = 1'b1;
		@(posedge core_clk);
		#2 syncReq = 1'b0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			#2 n++;
		end
		chk(n < 3000 && lowTime >= RESP - 1 && lowTime <= RESP + 1, "reply low time");
		chk(link.tgtOe_n === 1'b0 && link.tgtOut === 1'b1 && syncBusy === 1'b1, "reply speedup not driven");
		chk(srCnt == s + 1, "no single soft reset");
		ackPending = 1'b0;
		repeat (100) @(posedge core_clk);
		#2 chk(busy === 1'b0 && syncBusy === 1'b0 && link.tgtOe_n === 1'b1, "link not idle");
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence; a full run is some 3000 cycles.
	initial begin
		rst_n = 1'b0;
		syncReq = 1'b0;
		ackPending = 1'b0;
		benchLow = 1'b0;
		repeat (16) @(posedge core_clk);
		#2 rst_n = 1'b1;
		t_short();
		t_sync(1'b0);
		t_short();
		t_sync(1'b1);
		final_report();
	end
	// Watchdog well beyond the expected run.
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
